// *** sls_assertions.sv ***
// Port checker for the stall level selector.
// Assumes binding into sls_stall_monitor; CONFIG mirrored from APB writes.
`timescale 1ns/1ps
module sls_assertions
  import sls_pkg::*;
#(
  parameter longint MIN_ON_CYCLES = OL_MIN_ON_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [FW-1:0] out_freq,
  input wire logic [LW-1:0] out_current,
  input wire logic regen_avoid_stall,
  input wire logic [LW-1:0] active_level,
  input wire logic torque_limit_mode,
  input wire logic stall_active,
  input wire logic accel_hold,
  input wire logic decel_cmd,
  input wire logic decel_hold,
  input wire logic overload_flag,
  input wire logic stall_stop_fault,
  input wire logic output_shutoff
);
  logic [2:0] cfg_reg, cfg_next;
  logic [31:0] on_reg, on_next;
  logic wr, flag_int, engaged;
  // --------------------
  // Helper state
  // --------------------
  // Polarity undone here so flag checks hold for both settings
  assign wr = psel && penable && pwrite;
  assign flag_int = overload_flag ^ cfg_reg[2];
  assign engaged = stall_active || regen_avoid_stall;
  always_comb begin
    cfg_next = cfg_reg;
    if (wr && paddr == A_CONFIG) begin
      cfg_next = pwdata[2:0];
    end
    on_next = flag_int ? on_reg + 32'h1 : 32'h0;
  end
  // Cycles the flag has stood on, cleared when it drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= 3'h0;
      on_reg <= 32'h0;
    end else begin
      cfg_reg <= cfg_next;
      on_reg <= on_next;
    end
  end
  // --------------------
  // Properties
  // --------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_SHUTOFF: assert property (
    output_shutoff == stall_stop_fault) else $error("shutoff not fault");
  AST_STALL_CMP: assert property (
    $past(presetn) |-> stall_active == $past(out_current > active_level))
    else $error("stall compare wrong");
  AST_CMDS: assert property (
    (accel_hold || decel_cmd || decel_hold) ==
      (stall_active && !stall_stop_fault)) else $error("commands wrong");
  AST_TORQUE: assert property (
    torque_limit_mode == cfg_reg[0]) else $error("torque mode wrong");
  AST_FLAG_CAUSE: assert property (
    $rose(flag_int) |-> $past(engaged)) else $error("flag without cause");
  AST_FLAG_MIN_ON: assert property (
    $fell(flag_int) |-> on_reg >= MIN_ON_CYCLES) else $error("flag short");
  AST_FLAG_DROP: assert property (
    flag_int && !engaged && on_reg > MIN_ON_CYCLES + 1 |=> !flag_int)
    else $error("flag stuck on");
  AST_FAULT_CAUSE: assert property (
    $rose(stall_stop_fault) |->
      $past(stall_active && out_freq <= FREQ_STOP_LIMIT) &&
      $past(stall_active, 8)) else $error("fault without dwell");
  AST_FAULT_STICKY: assert property (
    stall_stop_fault && !(wr && paddr == A_STATUS && pwdata[ST_FAULT])
    |=> stall_stop_fault) else $error("fault lost");
  COV_FLAG: cover property ($rose(flag_int));
  COV_FAULT: cover property ($rose(stall_stop_fault));
  COV_DECEL: cover property (decel_cmd ##1 decel_cmd);
endmodule

bind sls_stall_monitor sls_assertions #(
  .MIN_ON_CYCLES(MIN_ON_CYCLES)
) u_chk (.*);

// *** sls_drive_model.sv ***
// Behavioural drive loop: holds output frequency and current.
// Assumes the bench loads new operating points between stalls.
`timescale 1ns/1ps
module sls_drive_model
  import sls_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [FW-1:0] freq_in,
  input wire logic [LW-1:0] cur_in,
  input wire logic decel_cmd,
  input wire logic output_shutoff,
  output logic [FW-1:0] out_freq,
  output logic [LW-1:0] out_current
);
  logic [FW-1:0] freq_reg, freq_next;
  logic [LW-1:0] cur_reg, cur_next;
  // Load wins; a trip stops the motor; decel stops at the trip floor
  always_comb begin
    freq_next = freq_reg;
    cur_next = cur_reg;
    if (load) begin
      freq_next = freq_in;
      cur_next = cur_in;
    end else if (output_shutoff) begin
      freq_next = FREQ_OFF;
      cur_next = LEVEL_ZERO;
    end else if (decel_cmd && freq_reg > FREQ_STOP_LIMIT) begin
      freq_next = freq_reg - 16'h0001;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_reg <= FREQ_OFF;
      cur_reg <= LEVEL_ZERO;
    end else begin
      freq_reg <= freq_next;
      cur_reg <= cur_next;
    end
  end
  assign out_freq = freq_reg;
  assign out_current = cur_reg;
endmodule

// *** sls_dwell_timer.sv ***
// Dwell timer: counts cycles while run is high, clears when it drops.
// Assumes limit is stable while run is high.
`timescale 1ns/1ps
module sls_dwell_timer #(
  parameter int W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [W-1:0] limit,
  output logic expired
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Stops at the limit so a long dwell never wraps back to zero
  always_comb begin
    if (!run) begin
      count_next = '0;
    end else if (count_reg >= limit) begin
      count_next = count_reg;
    end else begin
      count_next = count_reg + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  // A zero limit gives an immediate answer
  assign expired = run && (count_reg >= limit);

endmodule

// *** sls_level_curve.sv ***
// High-speed reduction curve for the stall level.
// Assumes settings in 0.1 % and 0.01 Hz units; purely combinational.
`timescale 1ns/1ps
module sls_level_curve
  import sls_pkg::*;
(
  input wire logic [LW-1:0] base_level,
  input wire logic [15:0] comp_factor,
  input wire logic [FW-1:0] begin_freq,
  input wire logic [FW-1:0] out_freq,
  output logic [LW-1:0] curve_level
);

  logic signed [47:0] a_term;
  logic signed [47:0] b_term;
  logic signed [47:0] num;
  logic signed [47:0] den;
  logic signed [47:0] lvl;

  // ----------------------------------------------------------------
  // Level = A + B * (L - A) / (L - B) * (K - 100) / 100
  // ----------------------------------------------------------------
  // Wide signed math; a factor below 100 pulls the level down
  always_comb begin
    a_term = '0;
    b_term = '0;
    num = '0;
    den = '0;
    lvl = 48'(base_level);
    if (comp_factor != CODE_9999 && out_freq > begin_freq) begin
      a_term = 48'(begin_freq) * 48'(base_level) / 48'(out_freq);
      b_term = 48'(begin_freq) * 48'(base_level) / 48'(FREQ_REF_400);
      num = b_term * (48'(base_level) - a_term)
            * (48'(comp_factor) - 48'(FACTOR_UNITY));
      den = (48'(base_level) - b_term) * 48'(FACTOR_UNITY);
      lvl = (den == 0) ? a_term : a_term + num / den;
    end
    // Factor 9999 leaves lvl at the base level over the whole range
    if (lvl < 0) begin
      curve_level = LEVEL_ZERO;
    end else if (lvl > 48'({LW{1'b1}})) begin
      curve_level = {LW{1'b1}};
    end else begin
      curve_level = lvl[LW-1:0];
    end
  end

endmodule

// *** sls_pkg.sv ***
// Constants, register map and field layout for the stall level selector.
// Assumes a 20 MHz APB clock; levels in 0.1 % steps, frequency in 0.01 Hz.
package sls_pkg;

  // ----------------------------------------------------------------
  // Clock and times
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 20_000_000;
  localparam longint OL_MIN_ON_MS = 100;
  localparam longint OL_DELAY_STEP_MS = 100;
  localparam longint STALL_STOP_S = 3;
  localparam longint OL_MIN_ON_CYC = OL_MIN_ON_MS * CLK_HZ / 1000;
  localparam longint OL_STEP_CYC = OL_DELAY_STEP_MS * CLK_HZ / 1000;
  localparam longint STALL_STOP_CYC = STALL_STOP_S * CLK_HZ;

  // ----------------------------------------------------------------
  // Data widths and special codes
  // ----------------------------------------------------------------
  localparam int LW = 12;
  localparam int FW = 16;
  localparam logic [FW-1:0] FREQ_RT_MODE = 16'hFFFF;
  localparam logic [FW-1:0] FREQ_OFF = 16'h0000;
  localparam logic [FW-1:0] FREQ_STOP_LIMIT = 16'h0032;
  localparam logic [FW-1:0] FREQ_REF_400 = 16'h9C40;
  localparam logic [15:0] CODE_9999 = 16'h270F;
  localparam logic [15:0] FACTOR_UNITY = 16'h0064;
  localparam logic [15:0] OL_DELAY_MAX = 16'h00FA;
  localparam logic [LW-1:0] LEVEL_ZERO = 12'h000;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_BASE_LVL = 8'h00;
  localparam logic [7:0] A_COMP = 8'h04;
  localparam logic [7:0] A_RED_FREQ = 8'h08;
  localparam logic [7:0] A_SEC_LVL = 8'h0C;
  localparam logic [7:0] A_SEC_FREQ = 8'h10;
  localparam logic [7:0] A_THR_LVL = 8'h14;
  localparam logic [7:0] A_THR_FREQ = 8'h18;
  localparam logic [7:0] A_OL_DELAY = 8'h1C;
  localparam logic [7:0] A_CONFIG = 8'h20;
  localparam logic [7:0] A_STATUS = 8'h24;

  // ----------------------------------------------------------------
  // Reset values and bit positions
  // ----------------------------------------------------------------
  localparam logic [LW-1:0] RST_LEVEL = 12'h5DC;
  localparam logic [15:0] RST_COMP = 16'h270F;
  localparam logic [FW-1:0] RST_RED_FREQ = 16'h1770;
  localparam logic [15:0] RST_OL_DELAY = 16'h0000;
  localparam int CFG_VECTOR = 0;
  localparam int CFG_ANALOG = 1;
  localparam int CFG_OL_LOW = 2;
  localparam int ST_FLAG = 16;
  localparam int ST_FAULT = 17;
  localparam int ST_STALL = 18;
  localparam int ST_TORQUE = 19;

  typedef enum logic [1:0] {
    SLS_CONSTANT,
    SLS_ACCEL,
    SLS_DECEL
  } sls_speed_e;

endpackage

// *** sls_stall_monitor.sv ***
// Stall level selection, overload flag and stall-stop trip with APB
// registers. Assumes inputs synchronous to pclk; the drive control loop
// acts on the hold/decelerate commands and the output shut-off.
//
// Overview of operation
// - Hold accel, decelerate, or hold decel while stalled
// - Flag on at stall, held over 100 ms
// - Flag off once output at or below level
// - Delay zero immediate, timed, 9999 never
// - Regeneration avoidance also drives the flag
// - Flag polarity selectable, codes 3 and 103
// - At 0.5 Hz for 3 s: trip, shut off
// - Above start frequency, level follows reduction curve
// - Factor 9999 keeps base level up to 400 Hz
// - Frequency 9999: select input picks second level (code uses 16'hFFFF for this, 9999 is a plain frequency)
// - Second/third level from zero to set frequency
// - Accelerating always uses the base level
// - Third level only while third select on
// - Frequency zero disables second or third level
// - Analog mode: second select forces fixed level
// - Second level 0 % gives zero level
// - Second select may come from any terminal
// - Vector control: base level is torque limit
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module sls_stall_monitor
  import sls_pkg::*;
#(
  parameter longint MIN_ON_CYCLES = OL_MIN_ON_CYC,
  parameter longint DELAY_STEP_CYCLES = OL_STEP_CYC,
  parameter longint STOP_CYCLES = STALL_STOP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [FW-1:0] out_freq,
  input wire logic [LW-1:0] out_current,
  input wire logic [1:0] speed_state,
  input wire logic second_function_select,
  input wire logic third_function_select,
  input wire logic regen_avoid_stall,
  input wire logic [LW-1:0] analog_level,
  output logic [LW-1:0] active_level,
  output logic torque_limit_mode,
  output logic stall_active,
  output logic accel_hold,
  output logic decel_cmd,
  output logic decel_hold,
  output logic overload_flag,
  output logic stall_stop_fault,
  output logic output_shutoff
);

  // ----------------------------------------------------------------
  // Settings registers
  // ----------------------------------------------------------------
  logic [LW-1:0] base_stall_level_reg, base_stall_level_next;
  logic [15:0] high_speed_compensation_reg, high_speed_compensation_next;
  logic [FW-1:0] reduction_begin_freq_reg, reduction_begin_freq_next;
  logic [LW-1:0] second_stall_level_reg, second_stall_level_next;
  logic [FW-1:0] second_stall_freq_reg, second_stall_freq_next;
  logic [LW-1:0] third_stall_level_reg, third_stall_level_next;
  logic [FW-1:0] third_stall_freq_reg, third_stall_freq_next;
  logic [15:0] overload_delay_timer_reg, overload_delay_timer_next;
  logic [2:0] config_reg, config_next;
  logic [31:0] prdata_reg, prdata_next;
  logic mapped;
  logic wr_en;
  logic fault_clear;
  logic [31:0] status_word;

  assign wr_en = psel && penable && pwrite && mapped;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;
  assign fault_clear = wr_en && (paddr == A_STATUS) && pwdata[ST_FAULT];

  // Address decode; only aligned words in the map answer without error
  always_comb begin
    if (paddr == A_BASE_LVL || paddr == A_COMP || paddr == A_RED_FREQ) begin
      mapped = 1'b1;
    end else if (paddr == A_SEC_LVL || paddr == A_SEC_FREQ) begin
      mapped = 1'b1;
    end else if (paddr == A_THR_LVL || paddr == A_THR_FREQ) begin
      mapped = 1'b1;
    end else if (paddr == A_OL_DELAY || paddr == A_CONFIG) begin
      mapped = 1'b1;
    end else if (paddr == A_STATUS) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // Register writes take effect in the access cycle
  always_comb begin
    base_stall_level_next = base_stall_level_reg;
    high_speed_compensation_next = high_speed_compensation_reg;
    reduction_begin_freq_next = reduction_begin_freq_reg;
    second_stall_level_next = second_stall_level_reg;
    second_stall_freq_next = second_stall_freq_reg;
    third_stall_level_next = third_stall_level_reg;
    third_stall_freq_next = third_stall_freq_reg;
    overload_delay_timer_next = overload_delay_timer_reg;
    config_next = config_reg;
    if (wr_en) begin
      if (paddr == A_BASE_LVL) begin
        base_stall_level_next = pwdata[LW-1:0];
      end else if (paddr == A_COMP) begin
        high_speed_compensation_next = pwdata[15:0];
      end else if (paddr == A_RED_FREQ) begin
        reduction_begin_freq_next = pwdata[FW-1:0];
      end else if (paddr == A_SEC_LVL) begin
        second_stall_level_next = pwdata[LW-1:0];
      end else if (paddr == A_SEC_FREQ) begin
        second_stall_freq_next = pwdata[FW-1:0];
      end else if (paddr == A_THR_LVL) begin
        third_stall_level_next = pwdata[LW-1:0];
      end else if (paddr == A_THR_FREQ) begin
        third_stall_freq_next = pwdata[FW-1:0];
      end else if (paddr == A_OL_DELAY) begin
        overload_delay_timer_next = pwdata[15:0];
      end else if (paddr == A_CONFIG) begin
        config_next = pwdata[2:0];
      end
    end
  end

  // Read data captured in the setup cycle so it stands all access long
  always_comb begin
    prdata_next = prdata_reg;
    if (psel && !penable && !pwrite) begin
      if (paddr == A_BASE_LVL) begin
        prdata_next = 32'(base_stall_level_reg);
      end else if (paddr == A_COMP) begin
        prdata_next = 32'(high_speed_compensation_reg);
      end else if (paddr == A_RED_FREQ) begin
        prdata_next = 32'(reduction_begin_freq_reg);
      end else if (paddr == A_SEC_LVL) begin
        prdata_next = 32'(second_stall_level_reg);
      end else if (paddr == A_SEC_FREQ) begin
        prdata_next = 32'(second_stall_freq_reg);
      end else if (paddr == A_THR_LVL) begin
        prdata_next = 32'(third_stall_level_reg);
      end else if (paddr == A_THR_FREQ) begin
        prdata_next = 32'(third_stall_freq_reg);
      end else if (paddr == A_OL_DELAY) begin
        prdata_next = 32'(overload_delay_timer_reg);
      end else if (paddr == A_CONFIG) begin
        prdata_next = 32'(config_reg);
      end else if (paddr == A_STATUS) begin
        prdata_next = status_word;
      end else begin
        prdata_next = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_stall_level_reg <= RST_LEVEL;
      high_speed_compensation_reg <= RST_COMP;
      reduction_begin_freq_reg <= RST_RED_FREQ;
      second_stall_level_reg <= RST_LEVEL;
      second_stall_freq_reg <= FREQ_OFF;
      third_stall_level_reg <= RST_LEVEL;
      third_stall_freq_reg <= FREQ_OFF;
      overload_delay_timer_reg <= RST_OL_DELAY;
      config_reg <= 3'h0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      base_stall_level_reg <= base_stall_level_next;
      high_speed_compensation_reg <= high_speed_compensation_next;
      reduction_begin_freq_reg <= reduction_begin_freq_next;
      second_stall_level_reg <= second_stall_level_next;
      second_stall_freq_reg <= second_stall_freq_next;
      third_stall_level_reg <= third_stall_level_next;
      third_stall_freq_reg <= third_stall_freq_next;
      overload_delay_timer_reg <= overload_delay_timer_next;
      config_reg <= config_next;
      prdata_reg <= prdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Level selection
  // ----------------------------------------------------------------
  logic [LW-1:0] curve_level;
  logic [LW-1:0] base_src;
  logic [LW-1:0] level_sel;

  sls_level_curve u_curve (
    .base_level(base_stall_level_reg),
    .comp_factor(high_speed_compensation_reg),
    .begin_freq(reduction_begin_freq_reg),
    .out_freq(out_freq),
    .curve_level(curve_level)
  );

  // Analog mode replaces the curve as the base source
  assign base_src = config_reg[CFG_ANALOG] ? analog_level : curve_level;

  // Select input arrives already mapped from its terminal
  always_comb begin
    level_sel = base_src;
    if (speed_state == SLS_ACCEL) begin
      level_sel = base_src;
    end else if (third_function_select && third_stall_freq_reg != FREQ_OFF
                 && third_stall_freq_reg != FREQ_RT_MODE
                 && (out_freq <= third_stall_freq_reg
                     || third_stall_level_reg == LEVEL_ZERO)) begin
      level_sel = third_stall_level_reg;
    end else if (second_stall_freq_reg == FREQ_OFF) begin
      level_sel = base_src;
    end else if (second_stall_freq_reg == FREQ_RT_MODE) begin
      if (second_function_select) begin
        level_sel = second_stall_level_reg;
      end
    end else if (second_stall_level_reg == LEVEL_ZERO) begin
      level_sel = LEVEL_ZERO;
    end else if (out_freq <= second_stall_freq_reg) begin
      // Smaller level wins so a weak second level cannot raise the limit
      if (second_stall_level_reg < base_src) begin
        level_sel = second_stall_level_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Overload flag, stall-stop trip and speed commands
  // ----------------------------------------------------------------
  logic [LW-1:0] level_reg;
  logic stall_reg, stall_next;
  logic flag_reg, flag_next;
  logic fault_reg, fault_next;
  logic acc_hold_reg, acc_hold_next;
  logic dec_cmd_reg, dec_cmd_next;
  logic dec_hold_reg, dec_hold_next;
  logic [31:0] min_on_reg, min_on_next;
  logic engaged;
  logic ol_expired;
  logic stop_expired;
  logic [31:0] ol_limit;

  assign stall_next = out_current > level_reg;
  assign engaged = stall_reg || regen_avoid_stall;
  assign ol_limit = 32'(longint'(overload_delay_timer_reg)
                        * DELAY_STEP_CYCLES);

  sls_dwell_timer #(.W(32)) u_ol_delay (
    .pclk(pclk),
    .presetn(presetn),
    .run(engaged && overload_delay_timer_reg <= OL_DELAY_MAX),
    .limit(ol_limit),
    .expired(ol_expired)
  );

  sls_dwell_timer #(.W(32)) u_stop (
    .pclk(pclk),
    .presetn(presetn),
    .run(stall_reg && out_freq <= FREQ_STOP_LIMIT),
    .limit(32'(STOP_CYCLES)),
    .expired(stop_expired)
  );

  // Flag keeps a minimum on time so short stalls are still visible
  always_comb begin
    flag_next = flag_reg;
    min_on_next = min_on_reg;
    if (flag_reg && min_on_reg != 32'h0000_0000) begin
      min_on_next = min_on_reg - 32'h0000_0001;
    end
    if (!flag_reg && ol_expired) begin
      flag_next = 1'b1;
      min_on_next = 32'(MIN_ON_CYCLES);
    end else if (flag_reg && !engaged && min_on_reg == 32'h0000_0000) begin
      flag_next = 1'b0;
    end else if (overload_delay_timer_reg == CODE_9999) begin
      flag_next = 1'b0;
    end
    // Trip is sticky; a new expiry in the clearing cycle wins
    fault_next = stop_expired || (fault_reg && !fault_clear);
    acc_hold_next = stall_next && !fault_next
                    && speed_state == SLS_ACCEL;
    dec_cmd_next = stall_next && !fault_next
                   && speed_state == SLS_CONSTANT;
    dec_hold_next = stall_next && !fault_next
                    && speed_state == SLS_DECEL;
  end

  // Everything re-evaluated each cycle; reset clears all but level_reg, which loads RST_LEVEL
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg <= RST_LEVEL;
      stall_reg <= 1'b0;
      flag_reg <= 1'b0;
      fault_reg <= 1'b0;
      acc_hold_reg <= 1'b0;
      dec_cmd_reg <= 1'b0;
      dec_hold_reg <= 1'b0;
      min_on_reg <= 32'h0000_0000;
    end else begin
      level_reg <= level_sel;
      stall_reg <= stall_next;
      flag_reg <= flag_next;
      fault_reg <= fault_next;
      acc_hold_reg <= acc_hold_next;
      dec_cmd_reg <= dec_cmd_next;
      dec_hold_reg <= dec_hold_next;
      min_on_reg <= min_on_next;
    end
  end

  assign active_level = level_reg;
  assign torque_limit_mode = config_reg[CFG_VECTOR];
  assign stall_active = stall_reg;
  assign accel_hold = acc_hold_reg;
  assign decel_cmd = dec_cmd_reg;
  assign decel_hold = dec_hold_reg;
  assign overload_flag = flag_reg ^ config_reg[CFG_OL_LOW];
  assign stall_stop_fault = fault_reg;
  assign output_shutoff = fault_reg;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[LW-1:0] = level_reg;
    status_word[ST_FLAG] = flag_reg;
    status_word[ST_FAULT] = fault_reg;
    status_word[ST_STALL] = stall_reg;
    status_word[ST_TORQUE] = config_reg[CFG_VECTOR];
  end

endmodule

// *** testbench.sv ***
// Self-checking bench for the stall level selector.
// Assumes short timer parameters; reads are checked from a queue.
`timescale 1ns/1ps
module testbench
  import sls_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, load;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [FW-1:0] out_freq, freq_in;
  logic [LW-1:0] out_current, cur_in, active_level, analog_level, b, l2, l3;
  logic [1:0] speed_state;
  logic rt, x9, regen, torque, stall, ah, dc, dh, flag, fault, shut;
  logic [63:0] expq[$];
  int bad_count, compares;
  sls_stall_monitor #(.MIN_ON_CYCLES(20), .DELAY_STEP_CYCLES(10),
    .STOP_CYCLES(50)) uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .out_freq, .out_current,
    .speed_state, .second_function_select(rt), .third_function_select(x9),
    .regen_avoid_stall(regen), .analog_level, .active_level,
    .torque_limit_mode(torque), .stall_active(stall), .accel_hold(ah),
    .decel_cmd(dc), .decel_hold(dh), .overload_flag(flag),
    .stall_stop_fault(fault), .output_shutoff(shut));
  sls_drive_model drv (.pclk, .presetn, .load, .freq_in, .cur_in,
    .decel_cmd(dc), .output_shutoff(shut), .out_freq, .out_current);
  // --------------------
  // Clock, checks and bus tasks
  // --------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Holds the request until pready is seen, then idles one cycle
  task automatic apb(input logic [7:0] a, input logic [31:0] d,
    input logic w = 1'b1);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] m = 32'hFFFF_FFFF);
    expq.push_back({m, e});
    apb(a, 32'h0, 1'b0);
  endtask
  // Read results taken off the queue as they appear
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check(prdata & expq[0][63:32], expq[0][31:0]);
      check(32'(pslverr), 32'(paddr > A_STATUS));
      void'(expq.pop_front());
    end
  end
  task automatic go(input logic [FW-1:0] f, input logic [LW-1:0] c,
    input int n);
    freq_in <= f;
    cur_in <= c;
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask
  task automatic lvl(input logic [FW-1:0] f, input logic [1:0] s,
    input logic [1:0] r, input logic [LW-1:0] e);
    speed_state <= s;
    {x9, rt} <= r;
    go(f, 12'h000, 3);
    rd(A_STATUS, {20'h0, e});
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  initial begin
    repeat (6000) @(posedge pclk);
    bad_count++;
    end_of_test;
  end
  // --------------------
  // Main sequence
  // --------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, load, freq_in, cur_in} = '0;
    {speed_state, rt, x9, regen, analog_level} = '0;
    seed = 32'h56AA;
    presetn = 1'b0;
    do_reset;
    rd(A_BASE_LVL, 32'h5DC);
    rd(A_COMP, 32'h270F);
    rd(A_RED_FREQ, 32'h1770);
    rd(A_SEC_FREQ, 32'h0);
    rd(A_OL_DELAY, 32'h0);
    rd(8'h30, 32'h0);
    b = 12'h100 + 12'($random(seed) & 32'h3FF);
    l2 = 12'h080 + 12'($random(seed) & 32'h3FF);
    l3 = 12'h040 + 12'($random(seed) & 32'h3FF);
    analog_level <= 12'($random(seed) & 32'h7FF);
    apb(A_BASE_LVL, {20'h0, b});
    lvl(16'h7530, SLS_CONSTANT, 2'h0, b);
    apb(A_SEC_LVL, {20'h0, l2});
    lvl(16'h0FA0, SLS_CONSTANT, 2'h1, b);
    apb(A_SEC_FREQ, 32'hFFFF);
    lvl(16'h0FA0, SLS_CONSTANT, 2'h1, l2);
    lvl(16'h0FA0, SLS_CONSTANT, 2'h0, b);
    lvl(16'h0FA0, SLS_ACCEL, 2'h1, b);
    apb(A_CONFIG, 32'h2);
    lvl(16'h0FA0, SLS_DECEL, 2'h0, analog_level);
    lvl(16'h0FA0, SLS_DECEL, 2'h1, l2);
    apb(A_CONFIG, 32'h0);
    apb(A_SEC_FREQ, 32'h1388);
    lvl(16'h0FA0, SLS_CONSTANT, 2'h0, l2 < b ? l2 : b);
    lvl(16'h1770, SLS_CONSTANT, 2'h0, b);
    apb(A_THR_LVL, {20'h0, l3});
    apb(A_THR_FREQ, 32'h1388);
    lvl(16'h0FA0, SLS_CONSTANT, 2'h2, l3);
    lvl(16'h0FA0, SLS_CONSTANT, 2'h0, l2 < b ? l2 : b);
    apb(A_SEC_LVL, 32'h0);
    lvl(16'h1770, SLS_CONSTANT, 2'h0, 12'h000);
    apb(A_SEC_FREQ, 32'h0);
    apb(A_BASE_LVL, 32'h5DC);
    apb(A_COMP, 32'h64);
    lvl(16'h2EE0, SLS_CONSTANT, 2'h0, 12'h2EE);
    apb(A_COMP, 32'h270F);
    // Two-step delay: off early, on later, off after the drop
    apb(A_OL_DELAY, 32'h2);
    go(16'h0BB8, 12'h700, 10);
    rd(A_STATUS, 32'h40000, 32'h50000);
    repeat (20) @(posedge pclk);
    rd(A_STATUS, 32'h10000, 32'h10000);
    go(16'h0BB8, 12'h000, 30);
    rd(A_STATUS, 32'h0, 32'h50000);
    apb(A_OL_DELAY, 32'h0);
    regen <= 1'b1;
    apb(A_CONFIG, 32'h4);
    check(32'(flag), 32'h0);
    regen <= 1'b0;
    repeat (30) @(posedge pclk);
    check(32'(flag), 32'h1);
    apb(A_CONFIG, 32'h0);
    apb(A_OL_DELAY, 32'h270F);
    go(16'h0028, 12'h700, 60);
    rd(A_STATUS, 32'h20000, 32'h30000);
    check(32'(shut), 32'h1);
    apb(A_STATUS, 32'h20000);
    rd(A_STATUS, 32'h0, 32'h20000);
    apb(A_CONFIG, 32'h1);
    rd(A_STATUS, 32'h80000, 32'h80000);
    do_reset;
    rd(A_CONFIG, 32'h0);
    rd(A_OL_DELAY, 32'h0);
    end_of_test;
  end
endmodule
